/* src/sfse_pkg.sv */
package sfse_pkg;
  // ----------------------------------------------------------------
  // instruction opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_BLOCK_WIPE = 8'hd8;
  localparam logic [7:0] OP_FULL_WIPE = 8'hc7;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE = 8'hab;
  // ----------------------------------------------------------------
  // status_flags layout and reset
  // ----------------------------------------------------------------
  localparam int SB_BUSY = 0;
  localparam int SB_LATCH = 1;
  localparam int SB_PB_LO = 2;
  localparam int SB_PB_HI = 3;
  localparam int SB_LOCK = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] PIPE_HIGH = 3'h7;
  // ----------------------------------------------------------------
  // frame lengths in whole bytes and in link bits, address fields
  // ----------------------------------------------------------------
  localparam logic [2:0] LEN_OP = 3'h1;
  localparam logic [2:0] LEN_STATUS = 3'h2;
  localparam logic [2:0] LEN_WIPE = 3'h4;
  localparam logic [2:0] LEN_MAX = 3'h7;
  localparam logic [2:0] BYTE_DATA = 3'h1;
  localparam logic [2:0] BYTE_ADDR_MID = 3'h2;
  localparam int ADDR_SECTOR_HI_BIT = 0;
  localparam int ADDR_SECTOR_LO_BIT = 7;
  localparam logic [5:0] LINK_OP_BITS = 6'h08;
  localparam logic [5:0] LINK_WAKE_BITS = 6'h20;
  localparam logic [5:0] LINK_WAKE_WRAP = 6'h27;
  localparam int MODE_SLEEP_BIT = 3;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int STATUS_WRITE_TIME_US = 100;
  localparam int BLOCK_WIPE_TIME_US = 1000;
  localparam int FULL_WIPE_TIME_US = 2000;
  localparam int SLEEP_ENTRY_TIME_NS = 3000;
  localparam int STATUS_WRITE_CYC = (STATUS_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam int BLOCK_WIPE_CYC = (BLOCK_WIPE_TIME_US * 1000 + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam int FULL_WIPE_CYC = (FULL_WIPE_TIME_US * 1000 + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // modes and self-timed jobs
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_BUSY = 4'b0010,
    ST_ENTER = 4'b0100,
    ST_SLEEP = 4'b1000
  } sfse_mode_t;
  typedef enum logic [2:0] {
    JOB_STATUS = 3'b001,
    JOB_BLOCK = 3'b010,
    JOB_FULL = 3'b100
  } sfse_job_t;
endpackage : sfse_pkg

/* src/sfse_link.sv */
`timescale 1ns/1ns
module sfse_link import sfse_pkg::*; #(
  // arbitrary identification value
  parameter logic [7:0] P_ID_CODE = 8'h5a
) (
  input wire logic i_link_clk,
  input wire logic i_rst,
  input wire logic i_sel_n,
  input wire logic i_sdi,
  input wire logic [7:0] i_status,
  input wire logic i_asleep,
  output logic o_bit_tgl,
  output logic o_bit_val,
  output logic o_sdo,
  output logic o_sdo_oe
);
  typedef struct packed {
    logic tgl;
    logic val;
    logic [8:0] s1;
    logic [8:0] s2;
    logic [8:0] s3;
    logic [8:0] held;
  } sfse_keep_t;
  typedef struct packed {
    logic [5:0] cnt;
    logic [7:0] sh;
    logic [7:0] op;
  } sfse_frame_t;
  typedef struct packed {
    logic [7:0] out;
    logic sdo;
    logic oe;
  } sfse_drive_t;
  sfse_keep_t k;
  sfse_keep_t next_k;
  sfse_frame_t f;
  sfse_frame_t next_f;
  sfse_drive_t d;
  sfse_drive_t next_d;
  logic [7:0] src;
  logic talk;

  // ----------------------------------------------------------------
  // rising edge: capture bits, hand each one over by toggle
  // ----------------------------------------------------------------
  always_comb begin
    next_k = k;
    next_k.s1 = {i_asleep, i_status};
    next_k.s2 = k.s1;
    next_k.s3 = k.s2;
    // the status word counts only once two samples agree, never half-changed
    if (k.s2 == k.s3) begin
      next_k.held = k.s3;
    end
    next_k.tgl = ~k.tgl;
    next_k.val = i_sdi; // [R27]
    next_f = f;
    next_f.sh = {f.sh[6:0], i_sdi}; // [R28]
    // counter wraps within the last byte so polling can run forever
    next_f.cnt = (f.cnt == LINK_WAKE_WRAP) ? LINK_WAKE_BITS : f.cnt + 6'h01;
    if (f.cnt == LINK_OP_BITS - 6'h01) begin
      next_f.op = next_f.sh;
    end
  end

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      k <= '0;
    end else begin
      k <= next_k;
    end
  end

  // frame state dies with the select, the clock may stop afterwards
  always_ff @(posedge i_link_clk or posedge i_sel_n) begin
    if (i_sel_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // ----------------------------------------------------------------
  // falling edge: shift answers out
  // ----------------------------------------------------------------
  always_comb begin
    next_d = d;
    src = P_ID_CODE;
    talk = 1'b0;
    if (f.op == OP_READ_STATUS && f.cnt >= LINK_OP_BITS && !k.held[8]) begin
      src = k.held[7:0]; // [R1] [R2]
      talk = 1'b1;
    end else if (f.op == OP_WAKE && f.cnt >= LINK_WAKE_BITS && !k.held[SB_BUSY]) begin
      talk = 1'b1; // [R23]
    end
    next_d.oe = talk;
    if (f.cnt[2:0] == 3'h0) begin
      next_d.sdo = src[7]; // [R28]
      next_d.out = {src[6:0], 1'b0};
    end else begin
      next_d.sdo = d.out[7];
      next_d.out = {d.out[6:0], 1'b0};
    end
  end

  always_ff @(negedge i_link_clk or posedge i_sel_n) begin
    if (i_sel_n) begin
      d <= '0; // [R21]
    end else begin
      d <= next_d; // [R27]
    end
  end

  assign o_bit_tgl = k.tgl;
  assign o_bit_val = k.val;
  assign o_sdo = d.sdo;
  assign o_sdo_oe = d.oe;
endmodule : sfse_link

/* src/sfse_top.sv */
// Operation
// R1: status can be read at any time, even during self-timed cycles.
// R2: status byte repeats while selected and clocked, for busy polling.
// R3: host should poll busy before sending new instructions.
// R4: status: lock b7, zeros b6-b4, protect b3-b2, latch b1, busy b0.
// R5: busy reads 1 during write, program or erase, else 0.
// R6: with write latch clear, status write, program and erase are refused.
// R7: lock and protect bits kept and writable; busy and latch read-only.
// R8: nonzero protect bits block program and sector erase in that region.
// R9: protect pin low with lock set makes status writes ineffective.
// R10: host sends a framed write-enable before each status write.
// R11: status write is opcode plus data byte, touching only lock and protect.
// R12: status write runs only on deselect right after data byte.
// R13: status write keeps busy high, then clears busy and latch.
// R14: sector erase takes three address bytes, wipes the whole sector.
// R15: address bits 23 down to 17 are ignored.
// R16: sector erase runs on exact deselect; busy held, latch cleared after.
// R17: sector erase on a protected sector is not started.
// R18: host holds select low through whole erase or sleep sequence.
// R19: bulk erase is opcode only, exact deselect, busy held, latch cleared.
// R20: bulk erase is discarded unless both protect bits are zero.
// R21: deselected and awake: output floats, every instruction accepted; code takes only status read while busy, plus wake in sleep entry.
// R22: sleep is opcode only, exact deselect, power-down after entry time.
// R23: in power-down only wake works; wake also shows identification byte.
// R24: power-on always starts in standby, not power-down.
// R25: opcodes d8, c7, b9, 05, 01, 06 as eight-bit values.
// R26: protect bits: none, top sector, upper two, all four sectors.
// R27: input sampled on rising link clock, output changes after falling.
// R28: bytes travel most significant bit first, whole bytes per frame.
`timescale 1ns/1ns
module sfse_top import sfse_pkg::*; #(
  parameter int unsigned P_STATUS_WRITE_CYC = STATUS_WRITE_CYC,
  parameter int unsigned P_BLOCK_WIPE_CYC = BLOCK_WIPE_CYC,
  parameter int unsigned P_FULL_WIPE_CYC = FULL_WIPE_CYC,
  parameter int unsigned P_SLEEP_ENTRY_CYC = SLEEP_ENTRY_CYC,
  // arbitrary identification value
  parameter logic [7:0] P_ID_CODE = 8'h5a
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_link_clk,
  input wire logic i_sel_n,
  input wire logic i_sdi,
  input wire logic i_wp_n,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic o_wipe_req,
  output logic o_wipe_all,
  output logic [1:0] o_wipe_sector,
  output logic o_asleep
);
  if (P_STATUS_WRITE_CYC < 1 || P_BLOCK_WIPE_CYC < 1 || P_FULL_WIPE_CYC < 1 ||
      P_SLEEP_ENTRY_CYC < 1) begin : g_bad_cycles
    $error("cycle counts must be at least one");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    sfse_mode_t mode;
    sfse_job_t job;
    logic [2:0] sel_p;
    logic sel_q;
    logic [2:0] wp_p;
    logic wp_q;
    logic [2:0] tg_p;
    logic tg_q;
    logic [2:0] bitcnt;
    logic [2:0] nbytes;
    logic [7:0] sh;
    logic [7:0] op;
    logic [7:0] data;
    logic sec_lo;
    logic lock;
    logic [1:0] pb;
    logic write_enable_latch;
    logic [2:0] pend;
    logic [31:0] timer;
    logic [7:0] stat;
    logic wipe_req;
    logic wipe_all;
    logic [1:0] wipe_sector;
  } sfse_sys_t;

  sfse_sys_t r;
  sfse_sys_t next_r;
  logic bit_ev;
  logic start;
  logic stop;
  logic exact;
  logic [1:0] sector;
  logic hw_lock;
  logic bit_tgl;
  logic bit_val;

  function automatic logic sector_locked(input logic [1:0] pb, input logic [1:0] sec);
    logic locked;
    locked = 1'b0;
    unique case (pb)
      2'b00: locked = 1'b0;
      2'b01: locked = (sec == 2'b11);
      2'b10: locked = sec[1];
      2'b11: locked = 1'b1;
    endcase
    return locked; // [R8] [R26]
  endfunction : sector_locked

  // ----------------------------------------------------------------
  // link side
  // ----------------------------------------------------------------
  sfse_link #(
    .P_ID_CODE(P_ID_CODE)
  ) u_link (
    .i_link_clk(i_link_clk),
    .i_rst(i_sys_rst),
    .i_sel_n(i_sel_n),
    .i_sdi(i_sdi),
    .i_status(r.stat),
    .i_asleep(r.mode[MODE_SLEEP_BIT]),
    .o_bit_tgl(bit_tgl),
    .o_bit_val(bit_val),
    .o_sdo(o_sdo),
    .o_sdo_oe(o_sdo_oe)
  );

  assign hw_lock = !r.wp_q && r.lock; // [R9]

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.wipe_req = 1'b0;
    next_r.sel_p = {r.sel_p[1:0], i_sel_n};
    next_r.wp_p = {r.wp_p[1:0], i_wp_n};
    next_r.tg_p = {r.tg_p[1:0], bit_tgl};
    if (r.sel_p[1] == r.sel_p[2]) begin
      next_r.sel_q = r.sel_p[2];
    end
    if (r.wp_p[1] == r.wp_p[2]) begin
      next_r.wp_q = r.wp_p[2];
    end
    if (r.tg_p[1] == r.tg_p[2]) begin
      next_r.tg_q = r.tg_p[2];
    end
    bit_ev = next_r.tg_q != r.tg_q;
    start = r.sel_q && !next_r.sel_q;
    stop = !r.sel_q && next_r.sel_q;

    // frame assembly; the bit value is held a full link period after its toggle
    if (start) begin
      next_r.bitcnt = 3'h0;
      next_r.nbytes = 3'h0;
    end
    if (bit_ev && !r.sel_q) begin
      next_r.sh = {r.sh[6:0], bit_val}; // [R28]
      next_r.bitcnt = r.bitcnt + 3'h1;
      if (r.bitcnt == 3'h7) begin
        if (r.nbytes == 3'h0) begin
          next_r.op = next_r.sh;
        end
        if (r.nbytes == BYTE_DATA) begin
          next_r.data = next_r.sh;
        end
        if (r.nbytes == BYTE_ADDR_MID) begin
          next_r.sec_lo = next_r.sh[ADDR_SECTOR_LO_BIT];
        end
        if (r.nbytes != LEN_MAX) begin
          next_r.nbytes = r.nbytes + 3'h1;
        end
      end
    end
    exact = (next_r.bitcnt == 3'h0);
    // only A16 and A15 pick the sector, upper bits are dropped
    sector = {next_r.data[ADDR_SECTOR_HI_BIT], next_r.sec_lo}; // [R14] [R15]

    // ----------------------------------------------------------------
    // instruction execution and self-timed cycles
    // ----------------------------------------------------------------
    unique case (r.mode)
      ST_IDLE: begin
        if (stop && exact) begin // [R21]
          case (next_r.op) // [R25]
            OP_SET_WRITE_LATCH: begin
              if (next_r.nbytes == LEN_OP) begin
                next_r.write_enable_latch = 1'b1;
              end
            end
            OP_WRITE_STATUS: begin
              if (next_r.nbytes == LEN_STATUS && r.write_enable_latch && !hw_lock) begin // [R6] [R9] [R12]
                next_r.mode = ST_BUSY;
                next_r.job = JOB_STATUS;
                next_r.timer = 32'(P_STATUS_WRITE_CYC - 1);
                next_r.pend = {next_r.data[SB_LOCK], next_r.data[SB_PB_HI:SB_PB_LO]}; // [R11]
              end
            end
            OP_BLOCK_WIPE: begin
              if (next_r.nbytes == LEN_WIPE && r.write_enable_latch &&
                  !sector_locked(r.pb, sector)) begin // [R16] [R17]
                next_r.mode = ST_BUSY;
                next_r.job = JOB_BLOCK;
                next_r.timer = 32'(P_BLOCK_WIPE_CYC - 1);
                next_r.wipe_req = 1'b1;
                next_r.wipe_all = 1'b0;
                next_r.wipe_sector = sector; // [R14]
              end
            end
            OP_FULL_WIPE: begin
              if (next_r.nbytes == LEN_OP && r.write_enable_latch && r.pb == 2'b00) begin // [R19] [R20]
                next_r.mode = ST_BUSY;
                next_r.job = JOB_FULL;
                next_r.timer = 32'(P_FULL_WIPE_CYC - 1);
                next_r.wipe_req = 1'b1;
                next_r.wipe_all = 1'b1;
                next_r.wipe_sector = 2'b00;
              end
            end
            OP_SLEEP: begin
              if (next_r.nbytes == LEN_OP) begin // [R22]
                next_r.mode = ST_ENTER;
                next_r.timer = 32'(P_SLEEP_ENTRY_CYC - 1);
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_BUSY: begin
        // new instructions are dropped here; only status polling is answered
        if (r.timer == 32'h0) begin
          next_r.mode = ST_IDLE;
          next_r.write_enable_latch = 1'b0; // [R13] [R16] [R19]
          if (r.job == JOB_STATUS) begin
            next_r.lock = r.pend[2]; // [R7] [R11]
            next_r.pb = r.pend[1:0];
          end
        end else begin
          next_r.timer = r.timer - 32'h1;
        end
      end
      ST_ENTER: begin
        if (r.timer == 32'h0) begin
          next_r.mode = ST_SLEEP; // [R22]
        end else begin
          next_r.timer = r.timer - 32'h1;
        end
        if (stop && next_r.op == OP_WAKE && next_r.nbytes != 3'h0) begin
          next_r.mode = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        // wake releases even without the signature being read out
        if (stop && next_r.op == OP_WAKE && next_r.nbytes != 3'h0) begin // [R23]
          next_r.mode = ST_IDLE;
        end
      end
      default: begin
        next_r.mode = ST_IDLE;
      end
    endcase

    next_r.stat = {next_r.lock, 3'b000, next_r.pb, next_r.write_enable_latch,
                   next_r.mode == ST_BUSY}; // [R4] [R5] [R7]
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      r <= '0;
      r.mode <= ST_IDLE; // [R24]
      r.job <= JOB_STATUS;
      r.sel_p <= PIPE_HIGH;
      r.sel_q <= 1'b1;
      r.wp_p <= PIPE_HIGH;
      r.wp_q <= 1'b1;
      r.stat <= STATUS_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign o_wipe_req = r.wipe_req;
  assign o_wipe_all = r.wipe_all;
  assign o_wipe_sector = r.wipe_sector;
  assign o_asleep = r.mode[MODE_SLEEP_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_status_layout: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R4]
    r.stat[6:4] == 3'b000 && r.stat[SB_LOCK] == r.lock &&
    r.stat[SB_PB_HI:SB_PB_LO] == r.pb && r.stat[SB_LATCH] == r.write_enable_latch)
    else $error("status byte layout wrong");

  a_busy_flag: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R5]
    r.stat[SB_BUSY] == (r.mode == ST_BUSY))
    else $error("busy flag disagrees with running cycle");

  a_latch_gate: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R6]
    $rose(r.mode == ST_BUSY) |-> $past(r.write_enable_latch))
    else $error("cycle started with write latch clear");

  a_frame_exact: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R12]
    $rose(r.mode == ST_BUSY) |-> r.bitcnt == 3'h0 && $past(r.sel_q) == 1'b0)
    else $error("cycle started on a partial byte");

  a_latch_done: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R13]
    (r.mode == ST_BUSY && r.timer == 32'h0) |=> !r.write_enable_latch && r.mode == ST_IDLE && !r.stat[SB_BUSY])
    else $error("latch or busy not cleared at completion");

  a_hw_lock: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R9]
    ($rose(r.mode == ST_BUSY) && r.job == JOB_STATUS) |-> !$past(hw_lock))
    else $error("status write accepted in hardware lock mode");

  a_bulk_gate: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R20]
    (r.wipe_req && r.wipe_all) |-> r.pb == 2'b00 && r.job == JOB_FULL)
    else $error("bulk erase started with protection set");

  a_sector_gate: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R17]
    (r.wipe_req && !r.wipe_all) |-> !sector_locked(r.pb, r.wipe_sector))
    else $error("protected sector erase started");

  a_wipe_pulse: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R16]
    r.wipe_req |-> r.mode == ST_BUSY ##1 !r.wipe_req)
    else $error("erase request not a single pulse in busy");

  a_sleep_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R23]
    r.mode == ST_SLEEP |=> r.mode == ST_SLEEP || r.mode == ST_IDLE)
    else $error("power-down left other than by wake");

  a_sleep_entry: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R22]
    $rose(r.mode == ST_SLEEP) |-> $past(r.mode == ST_ENTER) && $past(r.timer) == 32'h0)
    else $error("power-down entered before entry time");

  a_protect_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R11]
    !(r.mode == ST_BUSY && r.timer == 32'h0 && r.job == JOB_STATUS)
    |=> $stable({r.lock, r.pb}))
    else $error("protect bits changed outside a status write");
endmodule : sfse_top

/* testbench/sfse_host.sv */
`timescale 1ns/1ns
module sfse_host (
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  output logic o_link_clk,
  output logic o_sel_n,
  output logic o_sdi
);
  initial begin
    o_link_clk = 1'b0;
    o_sel_n = 1'b1;
    o_sdi = 1'b0;
  end
  // ----------------------------------------------------------------
  // one framed instruction; link clock runs only inside the frame
  // ----------------------------------------------------------------
  task automatic frame(input logic [39:0] tx, input int n, output logic [15:0] rx,
    output logic oe_any);
    int i;
    rx = 16'h0000;
    oe_any = 1'b0;
    #1;
    o_sel_n = 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      o_sdi = tx[i];
      #80;
      o_link_clk = 1'b1;
      rx = {rx[14:0], i_sdo};
      oe_any = oe_any | (i_sdo_oe === 1'b1);
      #80;
      o_link_clk = 1'b0;
    end
    // released input shows the inverse, not a stale level
    o_sdi = ~o_sdi;
    #40;
    o_sel_n = 1'b1;
    #80;
  endtask : frame
endmodule : sfse_host

/* testbench/test_sfse_top.sv */
`timescale 1ns/1ns
module test_sfse_top import sfse_pkg::*; ;
  localparam int W_ST = 1500;
  localparam int W_BK = 1500;
  localparam int W_FL = 2000;
  localparam int W_SL = 100;
  // arbitrary identification value
  localparam logic [7:0] ID = 8'h3c;
  logic i_sys_clk, i_sys_rst, i_wp_n, link_clk, sel_n, sdi;
  logic o_sdo, o_sdo_oe, o_wipe_req, o_wipe_all, o_asleep, sel_q, oe_any;
  logic [1:0] o_wipe_sector;
  logic [15:0] rx;
  logic [31:0] rnd;
  logic [7:0] nv;
  logic [2:0] wq[$];
  int errors, n_compared, cyc, s, p;
  sfse_top #(.P_STATUS_WRITE_CYC(W_ST), .P_BLOCK_WIPE_CYC(W_BK), .P_FULL_WIPE_CYC(W_FL),
    .P_SLEEP_ENTRY_CYC(W_SL), .P_ID_CODE(ID)) sfse_top_inst (.i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst), .i_link_clk(link_clk), .i_sel_n(sel_n), .i_sdi(sdi),
    .i_wp_n(i_wp_n), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_wipe_req(o_wipe_req),
    .o_wipe_all(o_wipe_all), .o_wipe_sector(o_wipe_sector), .o_asleep(o_asleep));
  sfse_host sfse_host_inst (.i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe), .o_link_clk(link_clk),
    .o_sel_n(sel_n), .o_sdi(sdi));
  initial i_sys_clk = 1'b0;
  always #2 i_sys_clk = ~i_sys_clk;
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic send(input logic [39:0] tx, input int n);
    @(negedge i_sys_clk);
    sfse_host_inst.frame(tx, n, rx, oe_any);
  endtask : send
  task automatic rd_check(input logic [7:0] exp);
    send({24'h0, OP_READ_STATUS, 8'h00}, 16);
    chk({8'h00, rx[7:0]}, {8'h00, exp});
    chk(16'(oe_any), 16'h0001);
  endtask : rd_check
  task automatic latch();
    send({32'h0, OP_SET_WRITE_LATCH}, 8);
  endtask : latch
  task automatic wait_idle();
    int k;
    for (k = 0; k < 20; k++) begin
      send({24'h0, OP_READ_STATUS, 8'h00}, 16);
      if (rx[0] === 1'b0) break;
    end
    chk(16'(rx[0]), 16'h0000);
  endtask : wait_idle
  task automatic wr_status(input logic [7:0] d);
    latch();
    send({24'h0, OP_WRITE_STATUS, d}, 16);
    send({16'h0, OP_READ_STATUS, 16'h0}, 24);
    chk(rx, {2{nv | 8'h03}});
    wait_idle();
    nv = d & 8'h8c;
    rd_check(nv);
  endtask : wr_status
  task automatic wipe(input logic [7:0] op, input logic [23:0] a, input int n);
    int pb, sec;
    logic ok;
    pb = nv[3:2];
    sec = a[16:15];
    // a frame of the wrong length must leave everything alone
    ok = (op == OP_FULL_WIPE) ? (pb == 0 && n == 8) :
      (n == 32 && !(pb != 0 && sec >= (pb == 3 ? 0 : 4 - pb)));
    latch();
    send({8'h0, op, a} >> (32 - n), n);
    send({24'h0, OP_READ_STATUS, 8'h00}, 16);
    chk(16'(rx[0]), 16'(ok));
    wait_idle();
    chk(16'(wq.size()), 16'(ok));
    if (ok && wq.size() > 0) begin
      chk(16'(wq.pop_front()), {13'h0, op == OP_FULL_WIPE, 2'(sec)});
    end
    wq.delete();
    if (ok) begin
      rd_check(nv);
    end
  endtask : wipe
  // ----------------------------------------------------------------
  // monitor and hang limit, sized less than a tenth above the planned sequence
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    sel_q <= sel_n;
    if (o_wipe_req === 1'b1) begin
      wq.push_back({o_wipe_all, o_wipe_sector});
    end
    if (sel_q === 1'b1 && sel_n === 1'b1 && i_sys_rst === 1'b0) begin
      chk(16'(o_sdo_oe), 16'h0000);
    end
    if (cyc == 95000) begin
      errors++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    i_sys_rst = 1'b1;
    i_wp_n = 1'b1;
    errors = 0;
    n_compared = 0;
    cyc = 0;
    sel_q = 1'b1;
    rnd = 32'd76950;
    nv = 8'h00;
    repeat (2) @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    rd_check(8'h00);
    chk(16'(o_asleep), 16'h0000);
    send({24'h0, OP_WRITE_STATUS, 8'h8c}, 16);
    rd_check(8'h00);
    latch();
    rd_check(8'h02);
    send({24'h0, OP_WRITE_STATUS, 8'h8c}, 15);
    rd_check(8'h02);
    rnd = lfsr(rnd);
    wr_status(rnd[7:0] | 8'h80);
    @(negedge i_sys_clk);
    i_wp_n = 1'b0;
    latch();
    send({24'h0, OP_WRITE_STATUS, 8'h00}, 16);
    rd_check(nv | 8'h02);
    @(negedge i_sys_clk);
    i_wp_n = 1'b1;
    wr_status(8'h04);
    wipe(OP_FULL_WIPE, 24'h0, 8);
    for (p = 1; p < 4; p++) begin
      wr_status(8'(p << 2));
      for (s = 0; s < 4; s++) begin
        rnd = lfsr(rnd);
        wipe(OP_BLOCK_WIPE, {rnd[23:17], 2'(s), rnd[14:0]}, 32);
      end
    end
    wr_status(8'h00);
    wipe(OP_BLOCK_WIPE, 24'h018000, 24);
    wipe(OP_FULL_WIPE, 24'h0, 7);
    wipe(OP_FULL_WIPE, 24'h0, 8);
    send({32'h0, OP_SLEEP}, 8);
    repeat (W_SL + 20) @(negedge i_sys_clk);
    chk(16'(o_asleep), 16'h0001);
    latch();
    send({24'h0, OP_READ_STATUS, 8'h00}, 16);
    chk(16'(oe_any), 16'h0000);
    send({OP_WAKE, 32'h0}, 40);
    chk({8'h00, rx[7:0]}, {8'h00, ID});
    chk(16'(o_asleep), 16'h0000);
    rd_check(nv);
    complete_run();
  end
endmodule : test_sfse_top
